// File: brr_defs.svh
// Offsets, field positions, reset values and sizes of the branch block
`ifndef BRR_DEFS_SVH
`define BRR_DEFS_SVH
`define BRR_OFF_LOOP 12'h000
`define BRR_OFF_EPI 12'h004
`define BRR_OFF_CFM 12'h008
`define BRR_OFF_SFM 12'h00c
`define BRR_OFF_GRD_LO 12'h010
`define BRR_OFF_GRD_HI 12'h014
`define BRR_JT_PAGE 6'h01
`define BRR_RST_LOOP 32'h0000_0000
`define BRR_RST_EPI 6'h00
`define BRR_RST_GUARD 64'h0000_0000_0000_0001
`define BRR_SLOT_FIRST 2'h0
`define BRR_SLOT_LAST 2'h2
`define BRR_SHORT_W 21
`define BRR_LONG_W 60
`define BRR_BUNDLE_SH 4
`define BRR_BUNDLE_BYTES 64'h0000_0000_0000_0010
`define BRR_GR_BASE 7'h20
`define BRR_FR_BASE 7'h20
`define BRR_FR_SIZE 7'h60
`define BRR_PR_BASE 6'h10
`define BRR_PR_SIZE 6'h30
`define BRR_PR_TOP 6'h3f
`define BRR_SOR_SH 3
`endif

// File: brr_pkg.sv
// Types shared by the branch and rotation block
package brr_pkg;
	typedef enum logic [3:0] {
		BRR_COND,
		BRR_CALL,
		BRR_RET,
		BRR_CLOOP,
		BRR_CTOP,
		BRR_CEXIT,
		BRR_WTOP,
		BRR_WEXIT,
		BRR_CLRRRB,
		BRR_CLRRRB_PR,
		BRR_ALLOC
	} brr_kind_t;
endpackage

// File: brr_branch_rotate.sv
// Branch resolution, rotating bases and register renaming with APB access
`timescale 1ns/100ps
`include "brr_defs.svh"
// What this block does
// - Targets are bundle aligned; execution resumes at slot 0.
// - Branches resolve one by one; a taken one ends the group.
// - Short relative target: sign-extended 21-bit displacement plus bundle.
// - Long relative target: 60-bit displacement over the 64-bit space.
// - Indirect target comes from the chosen jump target register.
// - Predicated jump is taken when its guard bit is one.
// - Call resolves alike, writes link and saves the frame marker.
// - Return is a predicated indirect jump restoring the frame.
// - Guard bit zero always reads one.
// - Counted loop decrements a non-zero count and jumps; zero falls.
// - Loop jumps outside the last slot raise an illegal fault.
// - Guard bits 16-63 and floats 32-127 always rotate.
// - Integer rotating region starts at 32, size in eights.
// - Guard bit 16 is the first stage predicate of counted loops.
// - Alloc changes rotating size only while all three bases are zero.
// - Base clear zeroes all bases; guard form zeroes guard base.
// - Modulo loop jumps rotate one position upward with wraparound until the epilog ends.
// - Rotation renames through three independent bases.
// - Integer bases rotate only with non-zero size; others always.
// - Bases decrement together modulo region size; floats modulo 96.
// - Counted modulo loop with count above zero continues, sets 16.
// - Call clears bases; return restores them from the saved marker.
module brr_branch_rotate
	import brr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire logic br_valid,
	input wire brr_kind_t br_kind,
	input wire logic [1:0] br_slot,
	input wire logic br_long,
	input wire logic br_indirect,
	input wire logic [5:0] br_guard,
	input wire logic [59:0] br_disp,
	input wire logic [2:0] br_target_sel,
	input wire logic [2:0] br_link_sel,
	input wire logic [3:0] br_alloc_sor,
	input wire logic [63:0] bundle_pointer,
	input wire logic [6:0] ren_int_idx,
	input wire logic [6:0] ren_flt_idx,
	input wire logic [5:0] ren_grd_idx,
	output logic res_valid_q,
	output logic res_taken_q,
	output logic [63:0] res_target_q,
	output logic [1:0] res_slot_q,
	output logic fault_q,
	output logic [63:0] fault_addr_q,
	output logic [6:0] ren_int_phys_q,
	output logic [6:0] ren_flt_phys_q,
	output logic [5:0] ren_grd_phys_q
);

	// Frame marker: size of rotating integers in eights and three bases
	logic [3:0] sor_q;
	logic [6:0] rrb_int_q;
	logic [6:0] rrb_flt_q;
	logic [5:0] rrb_grd_q;
	logic [3:0] sv_sor_q;
	logic [6:0] sv_int_q;
	logic [6:0] sv_flt_q;
	logic [5:0] sv_grd_q;
	logic [31:0] loop_count_reg_q;
	logic [5:0] epilog_count_reg_q;
	logic [63:0] guard_bit_file_q;
	logic [63:0] jump_target_file_q [0:7];

	logic go;
	logic is_loop;
	logic slot_bad;
	logic guard_val;
	logic [5:0] guard_phys;
	logic [5:0] top_phys;
	logic [63:0] disp_ext;
	logic [63:0] rel_tgt;
	logic [63:0] ind_tgt;
	logic [63:0] tgt;
	logic taken;
	logic cont;
	logic rot;
	logic wr_top;
	logic top_val;
	logic dec_loop;
	logic dec_epi;
	logic do_call;
	logic do_ret;
	logic clr_all;
	logic clr_grd;
	logic set_sor;
	logic alloc_bad;
	logic [6:0] int_size;
	logic apb_wr;
	logic apb_setup;
	logic [31:0] rd_data;
	logic rd_err;
	logic [6:0] grd_off_wrap;
	logic [6:0] grd_top_wrap;
	logic [6:0] grd_dec;
	logic [6:0] grd_ren_wrap;

	// Rotated index within one region, offset and base both below size
	function automatic logic [6:0] brr_wrap(
		input logic [6:0] off,
		input logic [6:0] rrb,
		input logic [6:0] size
	);
		logic [7:0] sum;
		sum = {1'b0, off} + {1'b0, rrb};
		if (sum >= {1'b0, size})
		begin
			sum = sum - {1'b0, size};
		end
		return sum[6:0];
	endfunction

	function automatic logic [6:0] brr_dec(
		input logic [6:0] rrb,
		input logic [6:0] size
	);
		return (rrb == 7'h00) ? size - 7'h01 : rrb - 7'h01;
	endfunction

	assign int_size = {sor_q, 3'h0};
	assign go = br_valid & ce;
	assign apb_setup = psel & ~penable & ce;
	assign apb_wr = apb_setup & pwrite;
	assign grd_dec = brr_dec({1'b0, rrb_grd_q}, {1'b0, `BRR_PR_SIZE});
	assign grd_ren_wrap = brr_wrap({1'b0, ren_grd_idx - `BRR_PR_BASE},
		{1'b0, rrb_grd_q}, {1'b0, `BRR_PR_SIZE});

	// Guard reads go through the guard base
	always_comb
	begin
		grd_off_wrap = brr_wrap({1'b0, br_guard - `BRR_PR_BASE},
			{1'b0, rrb_grd_q}, {1'b0, `BRR_PR_SIZE});
		grd_top_wrap = brr_wrap({1'b0, `BRR_PR_TOP - `BRR_PR_BASE},
			{1'b0, rrb_grd_q}, {1'b0, `BRR_PR_SIZE});
		guard_phys = br_guard;
		if (br_guard >= `BRR_PR_BASE)
		begin
			guard_phys = `BRR_PR_BASE + grd_off_wrap[5:0];
		end
		top_phys = `BRR_PR_BASE + grd_top_wrap[5:0];
		guard_val = (br_guard == 6'h00) ? 1'b1 : guard_bit_file_q[guard_phys];
	end

	// Target formation
	always_comb
	begin
		if (br_long)
		begin
			disp_ext = {{4{br_disp[`BRR_LONG_W-1]}}, br_disp};
		end
		else
		begin
			disp_ext = {{43{br_disp[`BRR_SHORT_W-1]}},
				br_disp[`BRR_SHORT_W-1:0]};
		end
		rel_tgt = bundle_pointer + (disp_ext << `BRR_BUNDLE_SH);
		ind_tgt = jump_target_file_q[br_target_sel];
		ind_tgt[3:0] = 4'h0;
		tgt = (br_indirect || br_kind == BRR_RET) ? ind_tgt : rel_tgt;
	end

	// Branch decision and side effects
	always_comb
	begin
		is_loop = (br_kind >= BRR_CLOOP) && (br_kind <= BRR_WEXIT);
		slot_bad = go & is_loop & (br_slot != `BRR_SLOT_LAST);
		alloc_bad = (br_alloc_sor != sor_q) && ((rrb_int_q != 7'h00) ||
			(rrb_flt_q != 7'h00) || (rrb_grd_q != 6'h00));
		taken = 1'b0;
		cont = 1'b0;
		rot = 1'b0;
		wr_top = 1'b0;
		top_val = 1'b0;
		dec_loop = 1'b0;
		dec_epi = 1'b0;
		do_call = 1'b0;
		do_ret = 1'b0;
		clr_all = 1'b0;
		clr_grd = 1'b0;
		set_sor = 1'b0;
		case (br_kind)
			BRR_COND:
			begin
				taken = guard_val;
			end
			BRR_CALL:
			begin
				taken = guard_val;
				do_call = guard_val;
			end
			BRR_RET:
			begin
				taken = guard_val;
				do_ret = guard_val;
			end
			BRR_CLOOP:
			begin
				taken = (loop_count_reg_q != 32'h0000_0000);
				dec_loop = taken;
			end
			BRR_CTOP, BRR_CEXIT:
			begin
				wr_top = 1'b1;
				if (loop_count_reg_q != 32'h0000_0000)
				begin
					cont = 1'b1;
					dec_loop = 1'b1;
					rot = 1'b1;
					top_val = 1'b1;
				end
				else if (epilog_count_reg_q != 6'h00)
				begin
					cont = (epilog_count_reg_q != 6'h01);
					dec_epi = 1'b1;
					rot = 1'b1;
				end
				taken = (br_kind == BRR_CTOP) ? cont : ~cont;
			end
			BRR_WTOP, BRR_WEXIT:
			begin
				wr_top = 1'b1;
				if (guard_val)
				begin
					cont = 1'b1;
					rot = 1'b1;
				end
				else if (epilog_count_reg_q != 6'h00)
				begin
					cont = (epilog_count_reg_q != 6'h01);
					dec_epi = 1'b1;
					rot = 1'b1;
				end
				taken = (br_kind == BRR_WTOP) ? cont : ~cont;
			end
			BRR_CLRRRB:
			begin
				clr_all = 1'b1;
			end
			BRR_CLRRRB_PR:
			begin
				clr_grd = 1'b1;
			end
			BRR_ALLOC:
			begin
				set_sor = ~alloc_bad;
			end
			default:
			begin
				taken = 1'b0;
			end
		endcase
	end

	// Result and fault outputs, one pulse per request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			res_valid_q <= 1'b0;
			res_taken_q <= 1'b0;
			res_target_q <= 64'h0;
			res_slot_q <= `BRR_SLOT_FIRST;
			fault_q <= 1'b0;
			fault_addr_q <= 64'h0;
		end
		else if (ce)
		begin
			res_valid_q <= br_valid;
			res_taken_q <= br_valid & ~slot_bad & taken;
			res_slot_q <= `BRR_SLOT_FIRST;
			fault_q <= slot_bad | (go & (br_kind == BRR_ALLOC) & alloc_bad);
			if (go)
			begin
				res_target_q <= tgt;
				fault_addr_q <= bundle_pointer;
			end
		end
	end

	// Frame marker bases and rotating size
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sor_q <= 4'h0;
			rrb_int_q <= 7'h00;
			rrb_flt_q <= 7'h00;
			rrb_grd_q <= 6'h00;
			sv_sor_q <= 4'h0;
			sv_int_q <= 7'h00;
			sv_flt_q <= 7'h00;
			sv_grd_q <= 6'h00;
		end
		else if (go && !slot_bad)
		begin
			if (do_call)
			begin
				sv_sor_q <= sor_q;
				sv_int_q <= rrb_int_q;
				sv_flt_q <= rrb_flt_q;
				sv_grd_q <= rrb_grd_q;
			end
			if (do_call || clr_all)
			begin
				rrb_int_q <= 7'h00;
				rrb_flt_q <= 7'h00;
				rrb_grd_q <= 6'h00;
			end
			else if (do_ret)
			begin
				sor_q <= sv_sor_q;
				rrb_int_q <= sv_int_q;
				rrb_flt_q <= sv_flt_q;
				rrb_grd_q <= sv_grd_q;
			end
			else if (clr_grd)
			begin
				rrb_grd_q <= 6'h00;
			end
			else if (rot)
			begin
				if (int_size != 7'h00)
				begin
					rrb_int_q <= brr_dec(rrb_int_q, int_size);
				end
				rrb_flt_q <= brr_dec(rrb_flt_q, `BRR_FR_SIZE);
				rrb_grd_q <= grd_dec[5:0];
			end
			if (set_sor)
			begin
				sor_q <= br_alloc_sor;
			end
		end
	end

	// Loop and epilog counts; branch update wins over a software write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			loop_count_reg_q <= `BRR_RST_LOOP;
			epilog_count_reg_q <= `BRR_RST_EPI;
		end
		else
		begin
			if (go && !slot_bad && dec_loop)
			begin
				loop_count_reg_q <= loop_count_reg_q - 32'h0000_0001;
			end
			else if (apb_wr && paddr == `BRR_OFF_LOOP)
			begin
				loop_count_reg_q <= pwdata;
			end
			if (go && !slot_bad && dec_epi)
			begin
				epilog_count_reg_q <= epilog_count_reg_q - 6'h01;
			end
			else if (apb_wr && paddr == `BRR_OFF_EPI)
			begin
				epilog_count_reg_q <= pwdata[5:0];
			end
		end
	end

	// Guard bits; the top rotating bit lands at 16 after the base moves
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			guard_bit_file_q <= `BRR_RST_GUARD;
		end
		else
		begin
			if (apb_wr && paddr == `BRR_OFF_GRD_LO)
			begin
				guard_bit_file_q[31:1] <= pwdata[31:1];
			end
			if (apb_wr && paddr == `BRR_OFF_GRD_HI)
			begin
				guard_bit_file_q[63:32] <= pwdata;
			end
			if (go && !slot_bad && wr_top)
			begin
				guard_bit_file_q[top_phys] <= top_val;
			end
		end
	end

	// Jump target file; a call link write wins over software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 8; i++)
			begin
				jump_target_file_q[i] <= 64'h0;
			end
		end
		else
		begin
			if (apb_wr && paddr[11:6] == `BRR_JT_PAGE &&
				paddr[1:0] == 2'h0)
			begin
				if (paddr[2])
				begin
					jump_target_file_q[paddr[5:3]][63:32] <= pwdata;
				end
				else
				begin
					jump_target_file_q[paddr[5:3]][31:0] <= pwdata;
				end
			end
			if (go && !slot_bad && do_call)
			begin
				jump_target_file_q[br_link_sel] <=
					bundle_pointer + `BRR_BUNDLE_BYTES;
			end
		end
	end

	// Renaming of the three rotating files
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ren_int_phys_q <= 7'h00;
			ren_flt_phys_q <= 7'h00;
			ren_grd_phys_q <= 6'h00;
		end
		else if (ce)
		begin
			ren_int_phys_q <= ren_int_idx;
			if (ren_int_idx >= `BRR_GR_BASE &&
				{1'b0, ren_int_idx} < {1'b0, `BRR_GR_BASE} + {1'b0, int_size})
			begin
				ren_int_phys_q <= `BRR_GR_BASE + brr_wrap(ren_int_idx -
					`BRR_GR_BASE, rrb_int_q, int_size);
			end
			ren_flt_phys_q <= ren_flt_idx;
			if (ren_flt_idx >= `BRR_FR_BASE)
			begin
				ren_flt_phys_q <= `BRR_FR_BASE + brr_wrap(ren_flt_idx -
					`BRR_FR_BASE, rrb_flt_q, `BRR_FR_SIZE);
			end
			ren_grd_phys_q <= ren_grd_idx;
			if (ren_grd_idx >= `BRR_PR_BASE)
			begin
				ren_grd_phys_q <= `BRR_PR_BASE + grd_ren_wrap[5:0];
			end
		end
	end

	// APB read mux
	always_comb
	begin
		rd_data = 32'h0;
		rd_err = 1'b0;
		case (paddr)
			`BRR_OFF_LOOP: rd_data = loop_count_reg_q;
			`BRR_OFF_EPI: rd_data = {26'h0, epilog_count_reg_q};
			`BRR_OFF_CFM: rd_data = {8'h0, sor_q, rrb_grd_q, rrb_flt_q, rrb_int_q};
			`BRR_OFF_SFM: rd_data = {8'h0, sv_sor_q, sv_grd_q, sv_flt_q, sv_int_q};
			`BRR_OFF_GRD_LO: rd_data = guard_bit_file_q[31:0];
			`BRR_OFF_GRD_HI: rd_data = guard_bit_file_q[63:32];
			default:
			begin
				if (paddr[11:6] == `BRR_JT_PAGE && paddr[1:0] == 2'h0)
				begin
					rd_data = paddr[2] ? jump_target_file_q[paddr[5:3]][63:32] :
						jump_target_file_q[paddr[5:3]][31:0];
				end
				else
				begin
					rd_err = 1'b1;
				end
			end
		endcase
	end

	// Zero-wait APB answer, captured at the setup edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (ce)
		begin
			pready_q <= psel & ~penable;
			pslverr_q <= psel & ~penable & rd_err;
			if (psel && !penable)
			begin
				prdata_q <= pwrite ? 32'h0 : rd_data;
			end
		end
	end

endmodule // brr_branch_rotate

// File: brr_branch_rotate_props.sv
// Concurrent checks on branch results and faults
`timescale 1ns/100ps
module brr_branch_rotate_chk
	import brr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic br_valid,
	input wire brr_kind_t br_kind,
	input wire logic [1:0] br_slot,
	input wire logic br_long,
	input wire logic br_indirect,
	input wire logic [5:0] br_guard,
	input wire logic [59:0] br_disp,
	input wire logic [63:0] bundle_pointer,
	input wire logic res_valid_q,
	input wire logic res_taken_q,
	input wire logic [63:0] res_target_q,
	input wire logic [1:0] res_slot_q,
	input wire logic fault_q,
	input wire logic [63:0] fault_addr_q
);
	logic [59:0] disp_q;
	logic [63:0] bp_q;
	always_ff @(posedge pclk)
	begin
		disp_q <= br_disp;
		bp_q <= bundle_pointer;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_req;
		br_valid && ce;
	endsequence
	sequence s_loop_bad;
		s_req ##0 br_kind >= BRR_CLOOP && br_kind <= BRR_WEXIT
			&& br_slot != 2'h2;
	endsequence
	sequence s_uncond;
		s_req ##0 br_kind == BRR_COND && br_guard == 6'h00 && !br_indirect;
	endsequence
	chk_res_pulse: assert property (
		s_req |=> res_valid_q)
		else $error("no result after request");
	chk_loop_slot: assert property (
		s_loop_bad |=> fault_q && !res_taken_q)
		else $error("misplaced loop jump not faulted");
	chk_fault_addr: assert property (
		fault_q |-> $past(br_valid) && fault_addr_q == bp_q)
		else $error("fault without request or wrong address");
	chk_slot_zero: assert property (
		res_valid_q |-> res_slot_q == 2'h0)
		else $error("resume slot not zero");
	chk_guard_zero: assert property (
		s_uncond |=> res_taken_q)
		else $error("guard zero jump not taken");
	chk_short_tgt: assert property (
		s_uncond ##0 !br_long |=>
		res_target_q == bp_q + {{39{disp_q[20]}}, disp_q[20:0], 4'h0})
		else $error("short target wrong");
	chk_long_tgt: assert property (
		s_uncond ##0 br_long |=> res_target_q == bp_q + {disp_q, 4'h0})
		else $error("long target wrong");
	chk_cond_clean: assert property (
		s_req ##0 br_kind == BRR_COND |=> !fault_q)
		else $error("fault on plain jump");
endmodule // brr_branch_rotate_chk

// File: brr_branch_rotate_tb_top.sv
// Self-checking bench for branch resolution and rotation
`timescale 1ns/100ps
module brr_branch_rotate_tb_top
	import brr_pkg::*;
;
	typedef struct packed {logic f; logic t; logic [63:0] a;} brr_exp_t;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata_q, rd;
	logic pready_q, pslverr_q, err, res_valid_q, res_taken_q, fault_q;
	logic br_valid = 0, br_long = 0, br_indirect = 0;
	brr_kind_t br_kind = BRR_COND;
	logic [1:0] br_slot = 0, res_slot_q;
	logic [5:0] br_guard = 0, ren_grd_idx = 6'h10, ren_grd_phys_q;
	logic [59:0] br_disp = 0;
	logic [2:0] br_target_sel = 0, br_link_sel = 0;
	logic [3:0] br_alloc_sor = 0;
	logic [63:0] bundle_pointer = 0, res_target_q, fault_addr_q, bp, r;
	logic [6:0] ren_int_idx = 7'h20, ren_flt_idx = 7'h20;
	logic [6:0] ren_int_phys_q, ren_flt_phys_q;
	brr_exp_t q[$];
	brr_exp_t e;
	integer seed = 22;
	int fail_count = 0, cmp_count = 0;
	always #50 pclk = ~pclk;
	brr_branch_rotate u_brr_branch_rotate (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q,
		.br_valid, .br_kind, .br_slot, .br_long, .br_indirect, .br_guard,
		.br_disp, .br_target_sel, .br_link_sel, .br_alloc_sor, .bundle_pointer,
		.ren_int_idx, .ren_flt_idx, .ren_grd_idx, .res_valid_q, .res_taken_q,
		.res_target_q, .res_slot_q, .fault_q, .fault_addr_q, .ren_int_phys_q,
		.ren_flt_phys_q, .ren_grd_phys_q);
	task automatic report_and_stop;
		$display("fails %0d compares %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [63:0] g, input logic [63:0] x);
		cmp_count++;
		if (g !== x)
		begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready_q !== 1'b1);
		rd = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		cmp({32'h0, rd}, {32'h0, x});
	endtask
	task automatic br(input brr_kind_t k, input logic [1:0] s,
		input logic t, input logic [63:0] a, input logic f);
		@(posedge pclk);
		br_valid <= 1'b1;
		br_kind <= k;
		br_slot <= s;
		q.push_back('{f, t, a});
		@(posedge pclk);
		br_valid <= 1'b0;
	endtask
	function automatic logic [63:0] rel(input logic l);
		if (l)
			return bp + {r[59:0], 4'h0};
		return bp + {{39{r[20]}}, r[20:0], 4'h0};
	endfunction
	// Result checker, sampled mid-cycle
	always @(negedge pclk)
		if (res_valid_q === 1'b1 || fault_q === 1'b1)
		begin
			e = q.pop_front();
			cmp(fault_q, e.f);
			cmp(res_taken_q, e.t);
			if (e.f)
				cmp(fault_addr_q, e.a);
			else if (e.t)
				cmp(res_target_q, e.a);
		end
	initial
	begin
		#200000;
		fail_count++;
		report_and_stop;
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		bp = {$random(seed), $random(seed)};
		bp[3:0] = 4'h0;
		r = {$random(seed), $random(seed)};
		bundle_pointer <= bp;
		br_disp <= r[59:0];
		br(BRR_COND, 2'h0, 1'b1, rel(1'b0), 1'b0);
		br_long <= 1'b1;
		br(BRR_COND, 2'h1, 1'b1, rel(1'b1), 1'b0);
		br_long <= 1'b0;
		br_guard <= 6'h05;
		br(BRR_COND, 2'h2, 1'b0, 64'h0, 1'b0);
		apb(1'b1, 12'h010, 32'h0000_0020);
		br(BRR_COND, 2'h2, 1'b1, rel(1'b0), 1'b0);
		rdc(12'h010, 32'h0000_0021);
		apb(1'b0, 12'h020, 32'h0);
		cmp(err, 1'b1);
		apb(1'b1, 12'h050, r[31:0]);
		apb(1'b1, 12'h054, r[63:32]);
		br_indirect <= 1'b1;
		br_target_sel <= 3'h2;
		br_guard <= 6'h00;
		br(BRR_COND, 2'h0, 1'b1, {r[63:4], 4'h0}, 1'b0);
		br_indirect <= 1'b0;
		br_link_sel <= 3'h3;
		br(BRR_CALL, 2'h0, 1'b1, rel(1'b0), 1'b0);
		rdc(12'h058, bp[31:0] + 32'h10);
		br_indirect <= 1'b1;
		br_target_sel <= 3'h3;
		br(BRR_RET, 2'h0, 1'b1, bp + 64'h10, 1'b0);
		br_indirect <= 1'b0;
		for (int k = 3; k < 8; k++)
			for (int s = 0; s < 2; s++)
				br(brr_kind_t'(k), 2'(s), 1'b0, bp, 1'b1);
		apb(1'b1, 12'h000, 32'h2);
		repeat (2) br(BRR_CLOOP, 2'h2, 1'b1, rel(1'b0), 1'b0);
		br(BRR_CLOOP, 2'h2, 1'b0, 64'h0, 1'b0);
		rdc(12'h000, 32'h0);
		apb(1'b1, 12'h000, 32'h1);
		br(BRR_CTOP, 2'h2, 1'b1, rel(1'b0), 1'b0);
		rdc(12'h008, 32'h000b_ef80);
		cmp(ren_flt_phys_q, 7'h7f);
		cmp(ren_grd_phys_q, 6'h3f);
		br_guard <= 6'h10;
		br(BRR_COND, 2'h2, 1'b1, rel(1'b0), 1'b0);
		br_alloc_sor <= 4'h1;
		br(BRR_ALLOC, 2'h0, 1'b0, bp, 1'b1);
		br(BRR_CLRRRB_PR, 2'h2, 1'b0, 64'h0, 1'b0);
		rdc(12'h008, 32'h0000_2f80);
		br(BRR_CLRRRB, 2'h2, 1'b0, 64'h0, 1'b0);
		br(BRR_ALLOC, 2'h0, 1'b0, 64'h0, 1'b0);
		rdc(12'h008, 32'h0010_0000);
		cmp(ren_grd_phys_q, 6'h10);
		// Integer rotation, epilog drain and while loop exit
		apb(1'b1, 12'h000, 32'h1);
		br(BRR_CTOP, 2'h2, 1'b1, rel(1'b0), 1'b0);
		apb(1'b1, 12'h004, 32'h2);
		cmp(ren_int_phys_q, 7'h27);
		br(BRR_CEXIT, 2'h2, 1'b0, 64'h0, 1'b0);
		br_guard <= 6'h06;
		br(BRR_WTOP, 2'h2, 1'b0, 64'h0, 1'b0);
		rdc(12'h004, 32'h0);
		rdc(12'h008, 32'h001b_6e85);
		// Request while the clock enable is low is ignored
		apb(1'b1, 12'h000, 32'h3);
		ce <= 1'b0;
		@(posedge pclk);
		br_valid <= 1'b1;
		br_kind <= BRR_CLOOP;
		br_slot <= 2'h2;
		@(posedge pclk);
		br_valid <= 1'b0;
		ce <= 1'b1;
		rdc(12'h000, 32'h3);
		repeat (2) @(posedge pclk);
		report_and_stop;
	end
endmodule // brr_branch_rotate_tb_top
bind brr_branch_rotate brr_branch_rotate_chk u_brr_branch_rotate_chk (
	.pclk, .presetn, .ce, .br_valid, .br_kind, .br_slot, .br_long,
	.br_indirect, .br_guard, .br_disp, .bundle_pointer, .res_valid_q,
	.res_taken_q, .res_target_q, .res_slot_q, .fault_q, .fault_addr_q);
